// [verilog/dri_pkg.sv]
// Shared constants, register map and carrier types of the DRAM reset and initialization block.
package dri_pkg;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int CLK_PERIOD_PS = 25000;
  localparam int T_INIT_NS = 500000;
  // Least time, rounded up to whole cycles.
  localparam int INIT_CYC = (T_INIT_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

  // ****************************************************************
  // Geometry
  // ****************************************************************
  localparam int NUM_BANKS = 8;
  localparam int BANK_W = 3;
  localparam int ADDR_W = 13;
  localparam int COL_W = 10;
  localparam int BEATS = 8;
  localparam int CORE_CLOCKS = 4;

  // ****************************************************************
  // Command codes {ras_n, cas_n, we_n} with chip select low
  // ****************************************************************
  localparam logic [2:0] CMD_MRS = 3'h0;
  localparam logic [2:0] CMD_ACT = 3'h3;
  localparam logic [2:0] CMD_READ = 3'h5;
  localparam logic [2:0] CMD_WRITE = 3'h4;
  localparam logic [2:0] CMD_PRE = 3'h2;

  // ****************************************************************
  // Mode register fields and command address bits
  // ****************************************************************
  localparam int MR0_BL_LSB = 0;
  localparam int MR0_BT_BIT = 3;
  localparam logic [1:0] BL_FIXED8 = 2'h0;
  localparam logic [1:0] BL_OTF = 2'h1;
  localparam logic [1:0] BL_FIXED4 = 2'h2;
  localparam int AP_BIT = 10;
  localparam int BC_BIT = 12;

  // ****************************************************************
  // Register map (byte offsets) and reset values
  // ****************************************************************
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_MR0 = 8'h08;
  localparam logic [7:0] OFS_MR1 = 8'h0c;
  localparam logic [7:0] OFS_MR2 = 8'h10;
  localparam logic [7:0] OFS_MR3 = 8'h14;
  localparam logic [7:0] OFS_BANKS = 8'h18;
  localparam logic [7:0] OFS_ERR = 8'h1c;
  localparam logic CTRL_RESET = 1'b1;
  localparam int ERR_EARLY_CKE = 0;
  localparam int ERR_CLOSED_BANK = 1;

  typedef enum logic [1:0] {ST_RESET, ST_INTERNAL, ST_WAIT_CKE, ST_READY} dri_init_e;

  typedef struct packed {
    logic cs_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
    logic [BANK_W-1:0] ba;
    logic [ADDR_W-1:0] a;
  } dri_cmd_s;

  typedef struct packed {
    logic go;
    logic write;
    logic chop;
    logic interleave;
    logic [BANK_W-1:0] bank;
    logic [ADDR_W-1:0] row;
    logic [COL_W-1:0] col;
  } dri_req_s;

  typedef struct packed {
    logic valid;
    logic write;
    logic live;
    logic [BANK_W-1:0] bank;
    logic [ADDR_W-1:0] row;
    logic [COL_W-1:0] col;
    logic [2:0] beat_rise;
    logic [2:0] beat_fall;
  } dri_beat_s;

endpackage

// [verilog/dri_burst.sv]
// Burst sequencer: turns one access into eight beat positions over four core clocks.
`timescale 1ns/1ps

module dri_burst (
  // Clock and reset
  input wire logic CLK,
  input wire logic SYS_RST,
  // Access request
  input dri_pkg::dri_req_s REQ,
  // Beat positions, two per clock
  output dri_pkg::dri_beat_s BEAT
);

  typedef struct packed {
    logic busy;
    logic [1:0] step;
    dri_pkg::dri_req_s req;
    logic [2:0] start;
    dri_pkg::dri_beat_s beat;
  } dri_burst_s;

  dri_burst_s s;
  dri_burst_s next_s;

  // Position of beat i for a start column within the eight-column group.
  function automatic logic [2:0] order(input logic [2:0] c, input logic [2:0] i,
                                       input logic il);
    logic [1:0] low;
    low = c[1:0] + i[1:0];
    order = il ? (c ^ i) : {c[2] ^ i[2], low};
  endfunction

  always_comb begin
    next_s = s;
    if (REQ.go) begin
      next_s.busy = 1'b1;
      next_s.step = 2'h0;
      next_s.req = REQ;
      // Writes always start at the nibble boundary.
      next_s.start = REQ.write ? {REQ.col[2], 2'h0} : REQ.col[2:0];
    end else if (s.busy) begin
      if (s.step == 2'(dri_pkg::CORE_CLOCKS - 1)) begin
        next_s.busy = 1'b0;
      end else begin
        next_s.step = s.step + 2'h1;
      end
    end
    // Two pin beats per core clock, four core clocks per access.
    next_s.beat.valid = next_s.busy;
    next_s.beat.write = next_s.req.write;
    next_s.beat.bank = next_s.req.bank;
    next_s.beat.row = next_s.req.row;
    next_s.beat.col = next_s.req.col;
    // Chopped bursts leave the upper four beats dead.
    next_s.beat.live = next_s.busy && !(next_s.req.chop && next_s.step[1]);
    next_s.beat.beat_rise = order(next_s.start, {next_s.step, 1'b0}, next_s.req.interleave);
    next_s.beat.beat_fall = order(next_s.start, {next_s.step, 1'b1}, next_s.req.interleave);
  end

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign BEAT = s.beat;

endmodule // dri_burst

// [verilog/dri_device.sv]
// Device-side reset, initialization, command decode and register access of the DRAM.
//
// Summary of operation
// - Eight banks, eightfold prefetch, two data words per clock at the pins.
// - Each access is one wide core word over four clocks, eight half-clock beats.
// - Accesses are bursts of eight or chopped four beats in programmed order.
// - Activate uses bank bits for bank, address bits for row; access needs open row.
// - Read/write carry bank and start column; bit 10 auto precharge, bit 12 chop.
// - Wait 500 us after reset release before clock enable; device initializes internally.
// - Termination stays off during reset and until clock enable is registered high.
`timescale 1ns/1ps

module dri_device #(
  parameter int INIT_CYCLES = dri_pkg::INIT_CYC
) (
  // Clock and reset
  input wire logic CLK,
  input wire logic SYS_RST,
  // Memory pins, synchronous to CLK
  input wire logic RESET_N,
  input wire logic CKE,
  input wire logic ODT,
  input dri_pkg::dri_cmd_s CMD,
  // Device status
  output logic ODT_TERM_EN,
  output logic INIT_DONE,
  output dri_pkg::dri_beat_s BEAT,
  // AHB-Lite slave
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic HREADYOUT,
  output logic HRESP,
  output logic [31:0] HRDATA
);

  localparam int CNT_W = $clog2(INIT_CYCLES + 1);

  typedef struct packed {
    dri_pkg::dri_init_e init;
    logic [CNT_W-1:0] cnt;
    logic cke_seen;
    logic odt_term;
    logic [3:0][dri_pkg::ADDR_W-1:0] mr;
    logic [dri_pkg::NUM_BANKS-1:0] open;
    logic [dri_pkg::NUM_BANKS-1:0][dri_pkg::ADDR_W-1:0] row;
    logic [1:0] err;
    logic chk;
    logic dp_wr;
    logic [7:0] dp_addr;
    logic [31:0] rdata;
    dri_pkg::dri_req_s req;
  } dri_state_s;

  dri_state_s s;
  dri_state_s next_s;

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    logic ap;
    logic [2:0] code;
    logic [7:0] ra;
    ap = HSEL && HTRANS[1] && HREADY;
    code = {CMD.ras_n, CMD.cas_n, CMD.we_n};
    ra = 8'h00;
    next_s = s;
    next_s.req = '0;

    // Register writes land in the data phase; error bits clear by writing one.
    if (s.dp_wr) begin
      unique case (s.dp_addr)
        dri_pkg::OFS_CTRL: next_s.chk = HWDATA[0];
        dri_pkg::OFS_ERR: next_s.err = s.err & ~HWDATA[1:0];
        default: ;
      endcase
    end

    if (!RESET_N) begin
      // Reset pin held low: termination off, all banks closed.
      next_s.init = dri_pkg::ST_RESET;
      next_s.cnt = '0;
      next_s.cke_seen = 1'b0;
      next_s.open = '0;
    end else begin
      unique case (s.init)
        dri_pkg::ST_RESET: begin
          // Warm and cold reset both restart the internal wait here.
          next_s.init = dri_pkg::ST_INTERNAL;
          next_s.cnt = '0;
        end
        dri_pkg::ST_INTERNAL: begin
          // Internal initialization runs for the full wait regardless of commands.
          if (CKE) begin
            next_s.err[dri_pkg::ERR_EARLY_CKE] = 1'b1;
          end
          if (s.cnt == CNT_W'(INIT_CYCLES - 1)) begin
            next_s.init = dri_pkg::ST_WAIT_CKE;
          end else begin
            next_s.cnt = s.cnt + CNT_W'(1);
          end
        end
        dri_pkg::ST_WAIT_CKE: begin
          if (CKE) begin
            next_s.cke_seen = 1'b1;
            next_s.init = dri_pkg::ST_READY;
          end
        end
        dri_pkg::ST_READY: begin
          if (CKE && !CMD.cs_n) begin
            unique case (code)
              dri_pkg::CMD_MRS: begin
                // Bank bits pick the register; every field is replaced.
                next_s.mr[CMD.ba[1:0]] = CMD.a;
              end
              dri_pkg::CMD_ACT: begin
                next_s.open[CMD.ba] = 1'b1;
                next_s.row[CMD.ba] = CMD.a;
              end
              dri_pkg::CMD_READ, dri_pkg::CMD_WRITE: begin
                if (!s.open[CMD.ba]) begin
                  next_s.err[dri_pkg::ERR_CLOSED_BANK] = 1'b1;
                end
                if (s.open[CMD.ba] || !s.chk) begin
                  next_s.req.go = 1'b1;
                  next_s.req.write = (code == dri_pkg::CMD_WRITE);
                  next_s.req.bank = CMD.ba;
                  next_s.req.row = s.row[CMD.ba];
                  next_s.req.col = CMD.a[dri_pkg::COL_W-1:0];
                  next_s.req.interleave = s.mr[0][dri_pkg::MR0_BT_BIT];
                  unique case (s.mr[0][dri_pkg::MR0_BL_LSB +: 2])
                    dri_pkg::BL_OTF: next_s.req.chop = !CMD.a[dri_pkg::BC_BIT];
                    dri_pkg::BL_FIXED4: next_s.req.chop = 1'b1;
                    default: next_s.req.chop = 1'b0;
                  endcase
                  if (CMD.a[dri_pkg::AP_BIT]) begin
                    next_s.open[CMD.ba] = 1'b0;
                  end
                end
              end
              dri_pkg::CMD_PRE: begin
                if (CMD.a[dri_pkg::AP_BIT]) begin
                  next_s.open = '0;
                end else begin
                  next_s.open[CMD.ba] = 1'b0;
                end
              end
              default: ;
            endcase
          end
        end
      endcase
    end

    // Termination only follows the pin once clock enable has been seen high.
    next_s.odt_term = ODT && next_s.cke_seen && RESET_N;

    // Address phase: reads sample the state that this cycle produces.
    if (ap) begin
      next_s.dp_wr = HWRITE;
      next_s.dp_addr = {HADDR[7:2], 2'h0};
      if (HADDR[31:8] == 24'h000000) begin
        ra = {HADDR[7:2], 2'h0};
      end else begin
        ra = 8'hff;
      end
      unique case (ra)
        dri_pkg::OFS_CTRL: next_s.rdata = {31'h0, next_s.chk};
        dri_pkg::OFS_STATUS: next_s.rdata = {27'h0, next_s.odt_term, next_s.cke_seen,
                                             next_s.init == dri_pkg::ST_READY,
                                             2'(next_s.init)};
        dri_pkg::OFS_MR0: next_s.rdata = {19'h0, next_s.mr[0]};
        dri_pkg::OFS_MR1: next_s.rdata = {19'h0, next_s.mr[1]};
        dri_pkg::OFS_MR2: next_s.rdata = {19'h0, next_s.mr[2]};
        dri_pkg::OFS_MR3: next_s.rdata = {19'h0, next_s.mr[3]};
        dri_pkg::OFS_BANKS: next_s.rdata = {24'h0, next_s.open};
        dri_pkg::OFS_ERR: next_s.rdata = {30'h0, next_s.err};
        default: next_s.rdata = 32'h00000000;
      endcase
    end else if (HREADY) begin
      next_s.dp_wr = 1'b0;
    end
  end

  // ****************************************************************
  // State register
  // ****************************************************************
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      s <= '0;
      s.chk <= dri_pkg::CTRL_RESET;
    end else begin
      s <= next_s;
    end
  end

  // ****************************************************************
  // Burst sequencer
  // ****************************************************************
  dri_burst u_burst (
    .CLK(CLK),
    .SYS_RST(SYS_RST),
    .REQ(s.req),
    .BEAT(BEAT)
  );

  assign ODT_TERM_EN = s.odt_term;
  assign INIT_DONE = (s.init == dri_pkg::ST_READY);
  assign HREADYOUT = 1'b1;
  assign HRESP = 1'b0;
  assign HRDATA = s.rdata;

endmodule // dri_device

// [tb/dri_ctl_model.sv]
// Controller model that drives the memory reset, clock enable, termination and command pins.
`timescale 1ns/1ps

module dri_ctl_model #(
  parameter int T_MRD = 4
) (
  // Clock
  input wire logic CLK,
  // Memory pins
  output logic RESET_N,
  output logic CKE,
  output logic ODT,
  output dri_pkg::dri_cmd_s CMD
);
  initial begin
    RESET_N = 1'b0;
    CKE = 1'b0;
    ODT = 1'b1;
    CMD = '1;
  end
  // Deselected address lines wander so a stale value is never trusted.
  task automatic idle(input int n);
    repeat (n) begin
      @(posedge CLK);
      CMD.cs_n <= 1'b1;
      CMD.a <= ~CMD.a;
    end
  endtask
  task automatic issue(input logic [2:0] op, input logic [2:0] ba, input logic [12:0] a);
    @(posedge CLK);
    CMD <= {1'b0, op, ba, a};
    idle(T_MRD);
  endtask
  task automatic term(input logic on);
    @(posedge CLK);
    ODT <= on;
  endtask
  task automatic power_up(input int n, input logic early);
    @(posedge CLK);
    RESET_N <= 1'b0;
    CKE <= 1'b0;
    idle(8);
    RESET_N <= 1'b1;
    ODT <= 1'b0;
    CKE <= early;
    idle(n);
    CKE <= 1'b1;
    idle(5);
  endtask
endmodule // dri_ctl_model

// [tb/dri_device_sva.sv]
// Concurrent checks on the ports of the DRAM reset and initialization block.
`timescale 1ns/1ps

module dri_device_sva #(
  parameter int INIT_CYCLES = 20
) (
  // Clock and reset
  input wire logic CLK,
  input wire logic SYS_RST,
  // Memory pins
  input wire logic RESET_N,
  input wire logic CKE,
  input dri_pkg::dri_cmd_s CMD,
  // Device status
  input wire logic ODT_TERM_EN,
  input wire logic INIT_DONE,
  input dri_pkg::dri_beat_s BEAT
);
  default clocking @(posedge CLK); endclocking
  default disable iff (SYS_RST);
  int run_cnt;
  logic acc;
  assign acc = CKE && !CMD.cs_n && CMD.ras_n && !CMD.cas_n;
  always_ff @(posedge CLK) begin
    if (SYS_RST || !RESET_N) begin
      run_cnt <= 0;
    end else if (run_cnt < 100000) begin
      run_cnt <= run_cnt + 1;
    end
  end
  sequence s_lead;
    BEAT.valid && BEAT.live ##1 BEAT.valid && BEAT.live;
  endsequence
  sequence s_tail;
    BEAT.valid [*2];
  endsequence
  chk_odt_reset: assert property (!RESET_N [*3] |-> !ODT_TERM_EN)
    else $error("termination on during reset");
  chk_odt_follow: assert property (ODT_TERM_EN |-> $past(ODT_TERM_EN) || $past(CKE))
    else $error("termination on before clock enable");
  chk_done_cke: assert property ($rose(INIT_DONE) |-> $past(CKE) && $past(RESET_N))
    else $error("ready without clock enable");
  chk_done_clear: assert property (!RESET_N |=> !INIT_DONE)
    else $error("ready kept through reset");
  chk_init_span: assert property (INIT_DONE |-> run_cnt > INIT_CYCLES)
    else $error("internal init too short");
  chk_burst_len: assert property ($rose(BEAT.valid) |-> s_lead ##1 s_tail)
    else $error("burst not four clocks");
  chk_burst_cause: assert property ($rose(BEAT.valid) |-> $past(acc, 2) && INIT_DONE)
    else $error("burst without access");
  chk_beat_pair: assert property (BEAT.valid && BEAT.live |->
    BEAT.beat_rise[2] == BEAT.beat_fall[2] && BEAT.beat_rise != BEAT.beat_fall)
    else $error("beat pair wrong");
  chk_half_swap: assert property ($rose(BEAT.valid) ##2 BEAT.live |->
    BEAT.beat_rise[2] != $past(BEAT.beat_rise[2], 2))
    else $error("second half not swapped");
  chk_write_align: assert property ($rose(BEAT.valid) && BEAT.write |->
    BEAT.beat_rise[1:0] == 2'h0)
    else $error("write start not aligned");
endmodule // dri_device_sva

bind dri_device dri_device_sva #(.INIT_CYCLES(INIT_CYCLES)) chk_u (
  .CLK(CLK), .SYS_RST(SYS_RST), .RESET_N(RESET_N), .CKE(CKE), .CMD(CMD),
  .ODT_TERM_EN(ODT_TERM_EN), .INIT_DONE(INIT_DONE), .BEAT(BEAT));

// [tb/ddr3_reset_init_sequence_tb_top.sv]
// Self-checking testbench of the DRAM reset and initialization block.
`timescale 1ns/1ps

module ddr3_reset_init_sequence_tb_top;
  localparam int N_INIT = 20;
  localparam logic [7:0] MODES [4] = '{8'h11, 8'hd5, 8'h2b, 8'hb6};
  logic clk, sys_rst, reset_n, cke, odt, odt_term_en, init_done;
  logic hsel, hwrite, hreadyout, hresp, rd_ph, chop;
  logic [1:0] htrans;
  logic [31:0] haddr, hwdata, hrdata;
  logic [12:0] mr [4];
  logic [7:0] b;
  logic [7:0] t;
  logic [2:0] c;
  logic [15:0] seed;
  logic [31:0] rq [$];
  logic [7:0] bq [$];
  int fails, checks_done;
  dri_pkg::dri_cmd_s cmd;
  dri_pkg::dri_beat_s beat;

  dri_device #(.INIT_CYCLES(N_INIT)) dut_u (
    .CLK(clk), .SYS_RST(sys_rst), .RESET_N(reset_n), .CKE(cke), .ODT(odt), .CMD(cmd),
    .ODT_TERM_EN(odt_term_en), .INIT_DONE(init_done), .BEAT(beat), .HSEL(hsel),
    .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata),
    .HREADY(hreadyout), .HREADYOUT(hreadyout), .HRESP(hresp), .HRDATA(hrdata));
  dri_ctl_model ctl_u (.CLK(clk), .RESET_N(reset_n), .CKE(cke), .ODT(odt), .CMD(cmd));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  function automatic logic [2:0] pos(input logic [2:0] c0, input logic [2:0] i, input logic il);
    return il ? c0 ^ i : {c0[2] ^ i[2], c0[1:0] + i[1:0]};
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fails++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic ahb(input logic wr, input logic [31:0] ad, input logic [31:0] wd);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= ad;
    do @(posedge clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    rd_ph <= !wr;
    do @(posedge clk); while (hreadyout !== 1'b1);
    rd_ph <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] ad, input logic [31:0] exp);
    rq.push_back(exp);
    ahb(1'b0, 32'(ad), 32'h0);
  endtask

  always @(posedge clk) begin
    if (rd_ph) begin
      check(hrdata, rq.pop_front());
      check(32'(hresp), 32'h0);
    end
    if (beat.valid === 1'b1) begin
      b = (bq.size() > 0) ? bq.pop_front() : 8'hff;
      check(32'({beat.write, beat.live, b[6] ? {beat.beat_rise, beat.beat_fall} : 6'h0}),
        32'(b));
      check(32'({beat.bank, beat.row}), 32'({3'h1, seed[12:0]}));
    end
  end
  initial begin
    #1000000;
    fails++;
    final_report();
  end
  initial begin
    sys_rst = 1'b1;
    {hsel, hwrite, rd_ph, htrans, haddr, hwdata} = '0;
    seed = 16'h8a43;
    repeat (6) @(posedge clk);
    sys_rst <= 1'b0;
    rd(dri_pkg::OFS_STATUS, 32'h0);
    rd(dri_pkg::OFS_CTRL, 32'h1);
    rd(8'h40, 32'h0);
    check(32'(odt_term_en), 32'h0);
    ctl_u.power_up(N_INIT + 2, 1'b0);
    check(32'(init_done), 32'h1);
    rd(dri_pkg::OFS_STATUS, 32'hf);
    for (int m = 0; m < 4; m++) begin
      seed = lfsr(seed);
      mr[m] = seed[12:0];
    end
    mr[1][0] = 1'b0;
    mr[0][8] = 1'b1;
    ctl_u.issue(dri_pkg::CMD_MRS, 3'h2, mr[2]);
    ctl_u.issue(dri_pkg::CMD_MRS, 3'h3, mr[3]);
    ctl_u.issue(dri_pkg::CMD_MRS, 3'h1, mr[1]);
    ctl_u.issue(dri_pkg::CMD_MRS, 3'h0, mr[0]);
    ctl_u.issue(3'h6, 3'h0, 13'h400);
    for (int m = 0; m < 4; m++) rd(dri_pkg::OFS_MR0 + 8'(4 * m), 32'(mr[m]));
    ctl_u.term(1'b1);
    repeat (3) @(posedge clk);
    check(32'(odt_term_en), 32'h1);
    foreach (MODES[k]) begin
      t = MODES[k];
      ctl_u.issue(dri_pkg::CMD_MRS, 3'h0, (mr[0] & 13'h1ff4) | 13'({t[7], 1'b0, t[6:5]}));
      seed = lfsr(seed);
      ctl_u.issue(dri_pkg::CMD_ACT, 3'h1, seed[12:0]);
      c = t[3] ? {t[2], 2'h0} : t[2:0];
      chop = t[6:5] == 2'h2 || (t[6:5] == 2'h1 && !t[4]);
      for (int j = 0; j < 4; j++) begin
        bq.push_back({t[3], (chop && j > 1) ? 7'h0 : {1'b1, pos(c, 3'(2 * j), t[7]),
          pos(c, 3'(2 * j + 1), t[7])}});
      end
      ctl_u.issue(t[3] ? dri_pkg::CMD_WRITE : dri_pkg::CMD_READ, 3'h1,
        {t[4], 2'h1, 7'h0, t[2:0]});
    end
    rd(dri_pkg::OFS_BANKS, 32'h0);
    ctl_u.issue(dri_pkg::CMD_READ, 3'h6, 13'h0);
    rd(dri_pkg::OFS_ERR, 32'h2);
    ahb(1'b1, 32'(dri_pkg::OFS_ERR), 32'h3);
    rd(dri_pkg::OFS_ERR, 32'h0);
    ctl_u.power_up(N_INIT + 2, 1'b1);
    rd(dri_pkg::OFS_ERR, 32'h1);
    rd(dri_pkg::OFS_MR1, 32'(mr[1]));
    rd(dri_pkg::OFS_STATUS, 32'hf);
    final_report();
  end
endmodule // ddr3_reset_init_sequence_tb_top
